// *** inc/diag_pkg.sv ***
// shared constants and types of the serial diagnostic transmitter
package diag_pkg;

  // =====================================================================
  // register map (byte addresses)
  localparam logic [31:0] KEY_OPEN_ADDR  = 32'hFFFF0880;
  localparam logic [31:0] CTRL_ADDR      = 32'hFFFF0884;
  localparam logic [31:0] KEY_CLOSE_ADDR = 32'hFFFF0888;
  localparam logic [31:0] DAT0_ADDR      = 32'hFFFF088C;
  localparam logic [31:0] DAT1_ADDR      = 32'hFFFF0890;
  localparam logic [31:0] DAT2_ADDR      = 32'hFFFF0894;

  // =====================================================================
  // key tokens and reset values
  localparam logic [15:0] KEY_OPEN_VALUE  = 16'h0007;
  localparam logic [15:0] KEY_CLOSE_VALUE = 16'h00B9;
  localparam logic [15:0] DATA_RESET      = 16'h0000;
  localparam logic [31:0] READ_ZERO       = 32'h00000000;

  // =====================================================================
  // packet shape
  localparam int unsigned DATA_BITS  = 8;
  localparam logic [3:0]  FRAME_BITS = 4'hC;
  localparam logic [3:0]  LAST_BIT   = 4'h0;
  localparam logic [1:0]  STOP_BITS  = 2'h3;
  localparam logic        START_BIT  = 1'b0;
  localparam logic        IDLE_LEVEL = 1'b1;
  localparam logic [2:0]  COUNT_MAX  = 3'h5;
  localparam int unsigned DATA_REGS  = 3;

  // =====================================================================
  // control register layout, bit 8 downward
  typedef struct packed {
    logic [3:0] state;
    logic [2:0] count;
    logic       reset;
    logic       enable;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '0;

  // one byte handed to the packet shifter
  typedef struct packed {
    logic                 load;
    logic [DATA_BITS-1:0] data;
  } tx_cmd_t;

endpackage

// *** logic/diag_packet_shifter.sv ***
// packet shifter: one byte out as a twelve-bit packet, one bit per baud tick
`timescale 1ns/1ps
module diag_packet_shifter (
  input  wire logic              clock_i,
  input  wire logic              rstn_i,
  input  wire logic              kill_i,
  input  wire diag_pkg::tx_cmd_t cmd_i,
  input  wire logic              tick_i,
  output logic                   line_o,
  output logic                   busy_o,
  output logic                   done_o
);

  logic [11:0] frame_reg;
  logic [3:0]  left_reg;
  logic        line_reg;
  logic        busy_reg;
  logic        done_reg;

  // =====================================================================
  // shift register
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frame_reg <= '0;
      left_reg  <= '0;
      line_reg  <= diag_pkg::IDLE_LEVEL;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (kill_i) begin
        busy_reg <= 1'b0;
        line_reg <= diag_pkg::IDLE_LEVEL;
      end else if (cmd_i.load) begin
        // stop, stop, even parity, data lsb first, start
        frame_reg <= {1'b0, diag_pkg::STOP_BITS, ^cmd_i.data, cmd_i.data};
        line_reg  <= diag_pkg::START_BIT;
        left_reg  <= diag_pkg::FRAME_BITS - 4'h1;
        busy_reg  <= 1'b1;
      end else if (busy_reg && tick_i) begin
        if (left_reg == diag_pkg::LAST_BIT) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
          line_reg <= diag_pkg::IDLE_LEVEL;
        end else begin
          line_reg  <= frame_reg[0];
          frame_reg <= {1'b0, frame_reg[11:1]};
          left_reg  <= left_reg - 4'h1;
        end
      end
    end
  end

  assign line_o = line_reg;
  assign busy_o = busy_reg;
  assign done_o = done_reg;

  // =====================================================================
  // checks
  bit_per_tick_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    busy_reg && !tick_i && !kill_i && !cmd_i.load |=> $stable(line_reg))
    else $error("line moved without a baud tick");

  idle_high_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    !busy_reg |-> line_reg == diag_pkg::IDLE_LEVEL)
    else $error("line not at stop level while idle");

  start_low_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    cmd_i.load && !kill_i |=> line_reg == diag_pkg::START_BIT && left_reg == diag_pkg::FRAME_BITS - 4'h1)
    else $error("packet did not open with start bit");

endmodule

// *** logic/serial_diag_transmitter.sv ***
// serial diagnostic transmitter: APB registers, key-protected control, byte sequencer
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps

module serial_diag_transmitter (
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic        baud_tick_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             diag_tx_o
);

  // =====================================================================
  // declarations
  logic                  pready_reg;
  logic                  pslverr_reg;
  logic [31:0]           prdata_reg;
  logic                  armed_reg;
  logic                  pending_reg;
  diag_pkg::ctrl_t       pend_reg;
  diag_pkg::ctrl_t       ctrl_reg;
  logic [15:0]           data_reg [diag_pkg::DATA_REGS];
  logic                  busy_reg;
  logic [2:0]            idx_reg;
  diag_pkg::tx_cmd_t     cmd_reg;
  logic                  shift_busy;
  logic                  frame_done;
  logic                  shift_line;
  logic                  access;
  logic                  bus_wr;
  logic                  commit;
  logic                  tx_kill;
  logic                  start;
  logic                  last_done;
  logic [3:0]            state_field;
  diag_pkg::ctrl_t       pend_next;

  // =====================================================================
  // decode helpers
  function automatic logic addr_mapped(input logic [31:0] a);
    return a == diag_pkg::KEY_OPEN_ADDR || a == diag_pkg::CTRL_ADDR ||
           a == diag_pkg::KEY_CLOSE_ADDR || a == diag_pkg::DAT0_ADDR ||
           a == diag_pkg::DAT1_ADDR || a == diag_pkg::DAT2_ADDR;
  endfunction

  function automatic logic [1:0] data_index(input logic [31:0] a);
    unique case (a)
      diag_pkg::DAT1_ADDR: return 2'h1;
      diag_pkg::DAT2_ADDR: return 2'h2;
      default:             return 2'h0;
    endcase
  endfunction

  function automatic logic is_data(input logic [31:0] a);
    return a == diag_pkg::DAT0_ADDR || a == diag_pkg::DAT1_ADDR || a == diag_pkg::DAT2_ADDR;
  endfunction

  // byte n (0..5): register n/2, earlier byte in the low half
  function automatic logic [7:0] byte_of(input logic [2:0] n, input logic [15:0] w0,
                                         input logic [15:0] w1, input logic [15:0] w2);
    logic [15:0] w;
    w = w0;
    unique case (n[2:1])
      2'h1:    w = w1;
      2'h2:    w = w2;
      default: w = w0;
    endcase
    return n[0] ? w[15:8] : w[7:0];
  endfunction

  // =====================================================================
  // apb slave: one wait state, then pready for one cycle
  assign access = psel_i && penable_i && !pready_reg;
  assign bus_wr = psel_i && penable_i && pready_reg && pwrite_i;

  assign state_field = busy_reg ? {1'b0, idx_reg + 3'h1} : 4'h0;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= diag_pkg::READ_ZERO;
    end else begin
      pready_reg  <= access;
      pslverr_reg <= access && !addr_mapped(paddr_i);
      prdata_reg  <= diag_pkg::READ_ZERO;
      if (access && !pwrite_i) begin
        if (paddr_i == diag_pkg::CTRL_ADDR) begin
          prdata_reg <= {23'h0, state_field, ctrl_reg.count, 1'b0, ctrl_reg.enable};
        end else if (is_data(paddr_i)) begin
          prdata_reg <= {16'h0, data_reg[data_index(paddr_i)]};
        end
        // keys and unmapped addresses read as zero
      end
    end
  end

  assign prdata_o  = prdata_reg;
  assign pready_o  = pready_reg;
  assign pslverr_o = pslverr_reg;

  // =====================================================================
  // unlock sequence: every completed write moves it along, reads do not
  assign commit = bus_wr && pending_reg && paddr_i == diag_pkg::KEY_CLOSE_ADDR &&
                  pwdata_i[15:0] == diag_pkg::KEY_CLOSE_VALUE;
  assign tx_kill = commit && pend_reg.reset;

  always_comb begin
    pend_next       = pwdata_i[8:0];
    pend_next.state = 4'h0;
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      armed_reg   <= 1'b0;
      pending_reg <= 1'b0;
      pend_reg    <= diag_pkg::CTRL_RESET;
    end else if (bus_wr) begin
      // only a correct opening key arms the next write
      armed_reg   <= paddr_i == diag_pkg::KEY_OPEN_ADDR &&
                     pwdata_i[15:0] == diag_pkg::KEY_OPEN_VALUE;
      // an unarmed control write leaves nothing pending
      pending_reg <= paddr_i == diag_pkg::CTRL_ADDR && armed_reg;
      if (paddr_i == diag_pkg::CTRL_ADDR) begin
        pend_reg <= pend_next;
      end
    end
  end

  // =====================================================================
  // control register
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_reg <= diag_pkg::CTRL_RESET;
    end else if (tx_kill) begin
      ctrl_reg <= diag_pkg::CTRL_RESET;
    end else if (commit) begin
      ctrl_reg <= pend_reg;
    end else if (last_done) begin
      ctrl_reg.enable <= 1'b0;
    end
  end

  // =====================================================================
  // data registers, written freely
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < diag_pkg::DATA_REGS; i++) begin
        data_reg[i] <= diag_pkg::DATA_RESET;
      end
    end else if (bus_wr && is_data(paddr_i)) begin
      data_reg[data_index(paddr_i)] <= pwdata_i[15:0];
    end
  end

  // =====================================================================
  // byte sequencer
  // count codes 110 and 111 are clamped to six bytes rather than left undefined
  assign start     = ctrl_reg.enable && !busy_reg && !shift_busy && !commit;
  assign last_done = busy_reg && frame_done && !tx_kill &&
                     (idx_reg == ctrl_reg.count || idx_reg == diag_pkg::COUNT_MAX);

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_reg <= 1'b0;
      idx_reg  <= 3'h0;
      cmd_reg  <= '0;
    end else begin
      cmd_reg.load <= 1'b0;
      if (tx_kill) begin
        busy_reg <= 1'b0;
        idx_reg  <= 3'h0;
      end else if (start) begin
        busy_reg     <= 1'b1;
        idx_reg      <= 3'h0;
        cmd_reg.load <= 1'b1;
        cmd_reg.data <= byte_of(3'h0, data_reg[0], data_reg[1], data_reg[2]);
      end else if (last_done) begin
        busy_reg <= 1'b0;
        idx_reg  <= 3'h0;
      end else if (busy_reg && frame_done) begin
        idx_reg      <= idx_reg + 3'h1;
        cmd_reg.load <= 1'b1;
        cmd_reg.data <= byte_of(idx_reg + 3'h1, data_reg[0], data_reg[1], data_reg[2]);
      end
    end
  end

  // =====================================================================
  // packet shifter and pin
  diag_packet_shifter shifter (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .kill_i  (tx_kill),
    .cmd_i   (cmd_reg),
    .tick_i  (baud_tick_i),
    .line_o  (shift_line),
    .busy_o  (shift_busy),
    .done_o  (frame_done)
  );

  assign diag_tx_o = shift_line;

  // =====================================================================
  // checks
  unarmed_write_drop_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    bus_wr && paddr_i == diag_pkg::CTRL_ADDR && !armed_reg |=> !pending_reg)
    else $error("unarmed control write was kept");

  open_key_arms_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    bus_wr && paddr_i == diag_pkg::KEY_OPEN_ADDR && pwdata_i[15:0] == diag_pkg::KEY_OPEN_VALUE
    |=> armed_reg)
    else $error("opening key did not arm");

  bad_close_drop_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    pending_reg && bus_wr && !commit |=> $stable(ctrl_reg.count) && !pending_reg)
    else $error("control changed without closing key");

  close_commit_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    commit && !pend_reg.reset |=> ctrl_reg.count == $past(pend_reg.count))
    else $error("valid sequence did not update control");

  key_read_zero_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    access && !pwrite_i && (paddr_i == diag_pkg::KEY_OPEN_ADDR || paddr_i == diag_pkg::KEY_CLOSE_ADDR)
    |=> prdata_reg == diag_pkg::READ_ZERO && pready_reg)
    else $error("key register read back nonzero");

  soft_reset_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    tx_kill |=> ctrl_reg == diag_pkg::CTRL_RESET && !busy_reg ##1 !shift_busy)
    else $error("reset bit did not clear transmitter");

  state_busy_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    access && !pwrite_i && paddr_i == diag_pkg::CTRL_ADDR |=> (prdata_reg[8:5] != 4'h0) == $past(busy_reg))
    else $error("state field does not follow transmission");

  first_byte_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    start |=> cmd_reg.load && cmd_reg.data == $past(data_reg[0][7:0]))
    else $error("first packet not low byte of first data register");

  count_limit_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    busy_reg |-> idx_reg <= diag_pkg::COUNT_MAX)
    else $error("more than six bytes in one transmission");

  end_idle_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    last_done && !commit |=> !busy_reg && !ctrl_reg.enable ##1 !busy_reg)
    else $error("transmitter did not stop after last byte");

  // =====================================================================
  // bus, register and sequencer checks
  ready_pulse_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    pready_reg |=> !pready_reg)
    else $error("ready held longer than one cycle");

  unmapped_error_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    access && !addr_mapped(paddr_i) |=> pslverr_reg && pready_reg)
    else $error("unmapped access gave no error");

  mapped_clean_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    access && addr_mapped(paddr_i) |=> !pslverr_reg)
    else $error("mapped access gave an error");

  error_with_ready_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    pslverr_reg |-> pready_reg)
    else $error("error flag without ready");

  unmapped_write_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    bus_wr && !addr_mapped(paddr_i) |=> $stable(data_reg[0]) && $stable(data_reg[1]) && $stable(data_reg[2]))
    else $error("unmapped write changed a data register");

  first_word_write_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    bus_wr && paddr_i == diag_pkg::DAT0_ADDR |=> data_reg[0] == $past(pwdata_i[15:0]))
    else $error("first data register not written");

  last_word_write_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    bus_wr && paddr_i == diag_pkg::DAT2_ADDR |=> data_reg[2] == $past(pwdata_i[15:0]))
    else $error("third data register not written");

  first_word_read_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    access && !pwrite_i && paddr_i == diag_pkg::DAT0_ADDR |=> prdata_reg == {16'h0, $past(data_reg[0])})
    else $error("first data register read back wrong");

  ctrl_reserved_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    access && !pwrite_i && paddr_i == diag_pkg::CTRL_ADDR |=> prdata_reg[31:9] == 23'h0 && prdata_reg[1] == 1'b0)
    else $error("control read shows reset or reserved bits");

  count_read_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    access && !pwrite_i && paddr_i == diag_pkg::CTRL_ADDR |=> prdata_reg[4:2] == $past(ctrl_reg.count))
    else $error("byte count read back wrong");

  second_byte_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    busy_reg && frame_done && !last_done && !tx_kill && idx_reg == 3'h0
    |=> cmd_reg.load && cmd_reg.data == $past(data_reg[0][15:8]))
    else $error("second packet not high byte of first data register");

  third_byte_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    busy_reg && frame_done && !last_done && !tx_kill && idx_reg == 3'h1
    |=> cmd_reg.load && cmd_reg.data == $past(data_reg[1][7:0]))
    else $error("third packet not low byte of second data register");

  sixth_byte_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    busy_reg && frame_done && !last_done && !tx_kill && idx_reg == 3'h4
    |=> cmd_reg.load && cmd_reg.data == $past(data_reg[2][15:8]))
    else $error("sixth packet not high byte of third data register");

  no_restart_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    !ctrl_reg.enable && !busy_reg |=> !busy_reg)
    else $error("transmission began without enable");

  commit_starts_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    commit && pend_reg.enable && !pend_reg.reset && !busy_reg && !shift_busy |=> start)
    else $error("enabled commit did not start a transmission");

  kill_quiet_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    tx_kill |=> diag_tx_o == diag_pkg::IDLE_LEVEL)
    else $error("pin not idle after transmitter reset");

  packet_gap_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    frame_done |-> diag_tx_o == diag_pkg::IDLE_LEVEL)
    else $error("pin not at stop level after a packet");

endmodule

// *** sim/diag_receiver.sv ***
// far-side diagnostic receiver model: decodes packets on baud ticks
`timescale 1ns/1ps
module diag_receiver (
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  input  wire logic       tick_i,
  input  wire logic       line_i,
  output logic            valid_o,
  output logic      [7:0] data_o,
  output logic            err_o
);
  // =====================================================================
  // frame decoder
  logic        active_reg;
  logic [3:0]  cnt_reg;
  logic [11:0] bits_reg;

  // each bit is sampled on the tick that ends it, so no mid-bit guess is needed
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      active_reg <= 1'b0;
      cnt_reg    <= 4'h0;
      bits_reg   <= 12'h000;
      valid_o    <= 1'b0;
      data_o     <= 8'h00;
      err_o      <= 1'b0;
    end else begin
      valid_o <= 1'b0;
      err_o   <= 1'b0;
      if (!active_reg) begin
        if (line_i == 1'b0) begin
          active_reg  <= 1'b1;
          bits_reg[0] <= 1'b0;
          cnt_reg     <= tick_i ? 4'h1 : 4'h0;
        end
      end else if (tick_i) begin
        bits_reg[cnt_reg] <= line_i;
        cnt_reg           <= cnt_reg + 4'h1;
        if (cnt_reg == 4'hB) begin
          active_reg <= 1'b0;
          valid_o    <= 1'b1;
          data_o     <= bits_reg[8:1];
          err_o      <= bits_reg[0] || (^bits_reg[9:1]) || !bits_reg[10] || !line_i;
        end
      end
    end
  end
endmodule

// *** sim/test_serial_diag_transmitter.sv ***
// self-checking testbench of the serial diagnostic transmitter
`timescale 1ns/1ps
module test_serial_diag_transmitter;
  // =====================================================================
  // signals
  localparam int BAUD = 8;
  localparam int CEIL = 20000;
  localparam logic [31:0] MAP [4] = '{diag_pkg::DAT0_ADDR, diag_pkg::DAT1_ADDR, diag_pkg::DAT2_ADDR,
                                      diag_pkg::CTRL_ADDR};
  logic        clock_i, rstn_i, psel, penable, pwrite, baud_tick, pready, pslverr, diag_tx, rx_valid, rx_err, e;
  logic [31:0] paddr, pwdata, prdata, r;
  logic [7:0]  rx_data;
  logic [7:0]  rxq [$];
  int          err_count = 0, total_checks = 0, frame_errs = 0, cycles = 0, tick_cnt = 0;

  serial_diag_transmitter dut (.clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .baud_tick_i(baud_tick), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .diag_tx_o(diag_tx));
  diag_receiver rx (.clock_i(clock_i), .rstn_i(rstn_i), .tick_i(baud_tick), .line_i(diag_tx),
    .valid_o(rx_valid), .data_o(rx_data), .err_o(rx_err));

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  // =====================================================================
  // baud timer, packet collection, timeout
  always @(posedge clock_i) begin
    tick_cnt  <= (tick_cnt == BAUD - 1) ? 0 : tick_cnt + 1;
    baud_tick <= (tick_cnt == BAUD - 1);
    cycles    <= cycles + 1;
    if (rx_valid === 1'b1) begin
      rxq.push_back(rx_data);
      if (rx_err !== 1'b0) frame_errs++;
    end
    if (cycles == CEIL) begin
      err_count++;
      results();
    end
  end

  // =====================================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // outputs read just after an edge show what that edge sampled; only the run ceiling ends the wait
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock_i);
    chk(32'(pready), 32'h0);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do begin
      @(posedge clock_i);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ctrl_seq(input logic [15:0] k0, input logic [31:0] c, input logic [15:0] k1, input int mid);
    apb(1'b1, diag_pkg::KEY_OPEN_ADDR, {16'h0000, k0});
    if (mid == 1) apb(1'b1, diag_pkg::DAT2_ADDR, 32'h00000000);
    apb(1'b1, diag_pkg::CTRL_ADDR, c);
    if (mid == 2) apb(1'b1, diag_pkg::DAT2_ADDR, 32'h00000000);
    apb(1'b1, diag_pkg::KEY_CLOSE_ADDR, {16'h0000, k1});
  endtask

  task automatic idle_wait(input int n);
    repeat (n) begin
      @(negedge clock_i);
      chk(32'(diag_tx), 32'(diag_pkg::IDLE_LEVEL));
    end
  endtask

  // =====================================================================
  // scenarios
  task automatic check_defaults();
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, MAP[i], 32'h00000000);
      chk(r, diag_pkg::READ_ZERO);
      chk(32'(e), 32'h0);
    end
    apb(1'b0, diag_pkg::KEY_OPEN_ADDR, 32'h00000000);
    chk(r, diag_pkg::READ_ZERO);
    apb(1'b0, diag_pkg::KEY_CLOSE_ADDR, 32'h00000000);
    chk(r, diag_pkg::READ_ZERO);
    apb(1'b0, 32'hFFFF0898, 32'h00000000);
    chk(32'(e), 32'h1);
    apb(1'b1, 32'hFFFF0898, 32'h0000FFFF);
    chk(32'(e), 32'h1);
  endtask

  task automatic bad_seq(input logic [15:0] k0, input logic [15:0] k1, input int mid);
    ctrl_seq(k0, 32'h00000015, k1, mid);
    idle_wait(40);
    apb(1'b0, diag_pkg::CTRL_ADDR, 32'h00000000);
    chk(r, diag_pkg::READ_ZERO);
  endtask

  task automatic abort_run();
    ctrl_seq(diag_pkg::KEY_OPEN_VALUE, 32'h00000015, diag_pkg::KEY_CLOSE_VALUE, 0);
    repeat (3 * BAUD) @(posedge clock_i);
    ctrl_seq(diag_pkg::KEY_OPEN_VALUE, 32'h00000002, diag_pkg::KEY_CLOSE_VALUE, 0);
    apb(1'b0, diag_pkg::CTRL_ADDR, 32'h00000000);
    chk(r, diag_pkg::READ_ZERO);
    idle_wait(14 * BAUD);
    // the receiver saw a cut frame; drop whatever it made of it
    rxq.delete();
    frame_errs = 0;
  endtask

  task automatic send_run(input int n, input logic [2:0] code);
    logic [7:0]  b [6];
    logic [31:0] w;
    int          i;
    for (i = 0; i < 6; i++) b[i] = 8'hA5 ^ 8'(i * 19 + n);
    for (i = 0; i < 3; i++) begin
      w = {16'h0000, b[2 * i + 1], b[2 * i]};
      apb(1'b1, MAP[i], w);
      apb(1'b0, MAP[i], 32'h00000000);
      chk(r, w);
    end
    rxq.delete();
    frame_errs = 0;
    ctrl_seq(diag_pkg::KEY_OPEN_VALUE, {27'h0, code, 2'b01}, diag_pkg::KEY_CLOSE_VALUE, 0);
    apb(1'b0, diag_pkg::CTRL_ADDR, 32'h00000000);
    chk(32'(r[8:5] != 4'h0), 32'h1);
    i = 0;
    while (rxq.size() < n && i < 3000) begin
      @(posedge clock_i);
      i++;
    end
    repeat (2 * BAUD) @(posedge clock_i);
    apb(1'b0, diag_pkg::CTRL_ADDR, 32'h00000000);
    chk(r & 32'hFFFFFFE3, 32'h00000000);
    repeat (14 * BAUD) @(posedge clock_i);
    chk(32'(rxq.size()), 32'(n));
    for (i = 0; i < n && i < rxq.size(); i++) chk(32'(rxq[i]), 32'(b[i]));
    chk(32'(frame_errs), 32'h0);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // =====================================================================
  // main sequence
  initial begin
    rstn_i    = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 32'h00000000;
    pwdata    = 32'h00000000;
    baud_tick = 1'b0;
    repeat (3) @(posedge clock_i);
    rstn_i <= 1'b1;
    @(negedge clock_i);
    chk(32'(diag_tx), 32'(diag_pkg::IDLE_LEVEL));
    check_defaults();
    bad_seq(16'h0006, diag_pkg::KEY_CLOSE_VALUE, 0);
    bad_seq(diag_pkg::KEY_OPEN_VALUE, diag_pkg::KEY_CLOSE_VALUE, 1);
    bad_seq(diag_pkg::KEY_OPEN_VALUE, 16'h00B8, 0);
    bad_seq(diag_pkg::KEY_OPEN_VALUE, diag_pkg::KEY_CLOSE_VALUE, 2);
    abort_run();
    for (int n = 1; n <= 6; n++) send_run(n, 3'(n - 1));
    // unused count code is clamped to the six-byte maximum
    send_run(6, 3'h7);
    results();
  end
endmodule
